// ---- src/sideband_pkg.sv ----
package sideband_pkg;
   // ======================================================================
   // Sizes and timing
   localparam int GPIO_PINS  = 7;
   localparam int DATA_W     = 32;
   localparam int ADDR_W     = 8;
   localparam int CLK_MHZ    = 100;
   localparam int CHARGE_NS  = 1000;
   localparam int SETTLE_NS  = 2000;
   localparam int CHARGE_CYC = (CHARGE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W      = 16;

   // ======================================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] A_GPIO_OE  = 8'h00;
   localparam logic [ADDR_W-1:0] A_GPIO_OUT = 8'h04;
   localparam logic [ADDR_W-1:0] A_GPIO_IN  = 8'h08;
   localparam logic [ADDR_W-1:0] A_STRAP    = 8'h0C;
   localparam logic [ADDR_W-1:0] A_CTRL     = 8'h10;
   localparam logic [ADDR_W-1:0] A_IRQ_ST   = 8'h14;
   localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h18;

   // ======================================================================
   // Field positions
   localparam int C_CLK    = 0;
   localparam int C_DAT    = 1;
   localparam int C_DATDIR = 2;
   localparam int C_PME    = 3;
   localparam int C_CLKSTP = 4;
   localparam int C_LED    = 5;
   localparam int CTRL_W   = 6;
   localparam int I_INS    = 0;
   localparam int I_EXT    = 1;
   localparam int I_MODE   = 2;
   localparam int IRQ_W    = 3;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

   typedef enum logic [1:0] {
      MODE_CONV = 2'b00,
      MODE_X66  = 2'b01,
      MODE_X133 = 2'b10
   } busmode_t;
endpackage : sideband_pkg

// ---- src/cap_sense_if.sv ----
`timescale 1ns/1ns
interface cap_sense_if import sideband_pkg::*; ;
   logic     pinLevel;
   logic     pullHigh;
   busmode_t mode;
   logic     done;
   modport sense (input pinLevel, output pullHigh, output mode, output done);
   modport user  (output pinLevel, input pullHigh, input mode, input done);
endinterface : cap_sense_if

// ---- src/cap_sense.sv ----
`timescale 1ns/1ns
module cap_sense import sideband_pkg::*; #(
   parameter int CHARGE = CHARGE_CYC,
   parameter int SETTLE = SETTLE_CYC
) (
   input wire logic   ref_clk,  // Bus clock.
   input wire logic   sys_rst,  // Synchronous reset.
   cap_sense_if.sense cs        // Sense pin and result.
);
   typedef enum logic [1:0] {
      S_CHARGE = 2'b00,
      S_HOLD   = 2'b01,
      S_DONE   = 2'b10
   } st_t;

   if (CHARGE < 1 || SETTLE < 1 || CHARGE >= 2**CNT_W || SETTLE >= 2**CNT_W) begin : g_bad
      $error("cap_sense: counts out of range.");
   end

   st_t              st_r;
   logic [CNT_W-1:0] cnt_r;
   logic             firstLvl_r;

   // A hard ground never rises; a lone capacitor keeps its charge once the
   // pull-up lets go, while the parallel resistor drains it.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r       <= S_CHARGE;
         cnt_r      <= '0;
         firstLvl_r <= 1'b0;
         cs.pullHigh <= 1'b1;
         cs.done    <= 1'b0;
         cs.mode    <= MODE_CONV;
      end else begin
         case (st_r)
            S_CHARGE: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(CHARGE - 1)) begin
                  firstLvl_r <= cs.pinLevel;
                  cs.pullHigh <= 1'b0;
                  cnt_r      <= '0;
                  st_r       <= S_HOLD;
               end
            end
            S_HOLD: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(SETTLE - 1)) begin
                  cs.mode <= !firstLvl_r ? MODE_CONV :
                             (cs.pinLevel ? MODE_X133 : MODE_X66);
                  cs.done <= 1'b1;
                  st_r    <= S_DONE;
               end
            end
            S_DONE:  st_r <= S_DONE;
            default: st_r <= S_CHARGE;
         endcase
      end
   end
endmodule : cap_sense

// ---- src/tap_ctrl.sv ----
`timescale 1ns/1ns
module tap_ctrl #(
   parameter int IR_W = 4
) (
   input  wire logic tck,   // Test clock.
   input  wire logic trstN, // Test reset, active low.
   input  wire logic tms,   // Test mode select.
   input  wire logic tdi,   // Scan input.
   output logic      tdo    // Scan output, last chain stage.
);
   typedef enum logic [3:0] {
      T_RESET = 4'h0, T_IDLE  = 4'h1, T_DRSEL = 4'h2, T_DRCAP = 4'h3,
      T_DRSH  = 4'h4, T_DREX1 = 4'h5, T_DRPAU = 4'h6, T_DREX2 = 4'h7,
      T_DRUPD = 4'h8, T_IRSEL = 4'h9, T_IRCAP = 4'hA, T_IRSH  = 4'hB,
      T_IREX1 = 4'hC, T_IRPAU = 4'hD, T_IREX2 = 4'hE, T_IRUPD = 4'hF
   } tap_t;

   if (IR_W < 2) begin : g_bad
      $error("tap_ctrl: IR_W must be at least 2.");
   end

   function automatic tap_t nextSt(tap_t s, logic m);
      case (s)
         T_RESET: nextSt = m ? T_RESET : T_IDLE;
         T_IDLE:  nextSt = m ? T_DRSEL : T_IDLE;
         T_DRSEL: nextSt = m ? T_IRSEL : T_DRCAP;
         T_DRCAP: nextSt = m ? T_DREX1 : T_DRSH;
         T_DRSH:  nextSt = m ? T_DREX1 : T_DRSH;
         T_DREX1: nextSt = m ? T_DRUPD : T_DRPAU;
         T_DRPAU: nextSt = m ? T_DREX2 : T_DRPAU;
         T_DREX2: nextSt = m ? T_DRUPD : T_DRSH;
         T_DRUPD: nextSt = m ? T_DRSEL : T_IDLE;
         T_IRSEL: nextSt = m ? T_RESET : T_IRCAP;
         T_IRCAP: nextSt = m ? T_IREX1 : T_IRSH;
         T_IRSH:  nextSt = m ? T_IREX1 : T_IRSH;
         T_IREX1: nextSt = m ? T_IRUPD : T_IRPAU;
         T_IRPAU: nextSt = m ? T_IREX2 : T_IRPAU;
         T_IREX2: nextSt = m ? T_IRUPD : T_IRSH;
         T_IRUPD: nextSt = m ? T_DRSEL : T_IDLE;
         default: nextSt = T_RESET;
      endcase
   endfunction : nextSt

   tap_t            st_r;
   logic [IR_W-1:0] irSh_r;
   logic [IR_W-1:0] ir_r;
   logic            bypass_r;

   always_ff @(posedge tck or negedge trstN) begin
      if (!trstN) st_r <= T_RESET;
      else        st_r <= nextSt(st_r, tms);
   end

   // Every instruction selects the one-bit bypass stage.
   always_ff @(posedge tck or negedge trstN) begin
      if (!trstN) begin
         irSh_r   <= '0;
         ir_r     <= '1;
         bypass_r <= 1'b0;
      end else begin
         if (st_r == T_IRCAP) irSh_r <= IR_W'(1);
         if (st_r == T_IRSH)  irSh_r <= {tdi, irSh_r[IR_W-1:1]};
         if (st_r == T_IRUPD) ir_r <= irSh_r;
         if (st_r == T_RESET) ir_r <= '1;
         if (st_r == T_DRCAP) bypass_r <= 1'b0;
         if (st_r == T_DRSH)  bypass_r <= tdi;
      end
   end

   // The output changes on the falling edge so the far end samples it safely.
   always_ff @(negedge tck or negedge trstN) begin
      if (!trstN) tdo <= 1'b0;
      else        tdo <= (st_r == T_IRSH) ? irSh_r[0] : bypass_r;
   end
endmodule : tap_ctrl

// ---- src/strap_sideband_and_hot_swap.sv ----
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ns
// What this block does
// - Each general pin is input-only or bidirectional per its output-enable bit.
// - Serial clock pin driven out for memory mode, input for SMBus mode.
// - Serial data pin bidirectional in memory mode, open-drain in SMBus mode.
// - Bus width strap high means 64-bit bus, low means 32-bit.
// - Frequency strap high assumes 100MHz clock, low assumes 133MHz.
// - Capability pull-up is driven so the sense pin level can be read.
// - Sense pin termination picks conventional, 133MHz or 66MHz extended mode.
// - Hot-swap works only while its enable is high; boards tie it low otherwise.
// - Hot-swap switch is watched for insertion and pending extraction.
// - Extraction LED lights when the board may be pulled.
// - Open-drain enumeration output pulls low on insertion or pending extraction.
// - Power event output asserts to request a power state change.
// - Clock-run signal is driven low or released to show clock status.
// - Test controller steps by mode select, synchronous to test clock.
// - Low test reset initialises the test controller.
module strap_sideband_and_hot_swap import sideband_pkg::*; #(
   parameter int GPIO_N = GPIO_PINS,
   parameter int CHARGE = CHARGE_CYC,
   parameter int SETTLE = SETTLE_CYC
) (
   input  wire logic              ref_clk,               // Bus clock.
   input  wire logic              sys_rst,               // Synchronous reset.
   input  wire logic [ADDR_W-1:0] regAddr,               // Register byte address.
   input  wire logic [DATA_W-1:0] regWdata,              // Write data.
   input  wire logic              regWr,                 // Write strobe.
   input  wire logic              regRd,                 // Read strobe.
   output logic      [DATA_W-1:0] regRdata,              // Read data, next cycle.
   output logic                   irq,                   // Level interrupt.
   input  wire logic [GPIO_N-1:0] gpioIn,                // General pin levels.
   output logic      [GPIO_N-1:0] gpioOut,               // General pin drive.
   output logic      [GPIO_N-1:0] gpioOeN,               // Low drives the pin.
   input  wire logic              serialPortSelectStrap, // High selects SMBus.
   input  wire logic              busWidthStrap,         // High selects 64-bit.
   input  wire logic              frequencySelectStrap,  // High selects 100MHz.
   input  wire logic              hotSwapEnableIn,       // Hot-swap enable strap.
   input  wire logic              hotSwapSwitchIn,       // High when seated.
   input  wire logic              serialClkIn,           // Serial clock level.
   output logic                   serialClkOut,          // Serial clock drive.
   output logic                   serialClkOeN,          // Low drives clock.
   input  wire logic              serialDataIn,          // Serial data level.
   output logic                   serialDataOut,         // Serial data drive.
   output logic                   serialDataOeN,         // Low drives data.
   input  wire logic              capabilitySensePin,    // Sense pin level.
   output logic                   capabilityPullupDrive, // Sense pull-up.
   output logic                   extractionLedOut,      // Extract LED on.
   output logic                   enumOut,               // Enumeration drive.
   output logic                   enumOeN,               // Low pulls it low.
   input  wire logic              pmeIn,                 // Power event level.
   output logic                   pmeOut,                // Power event drive.
   output logic                   pmeOeN,                // Low pulls it low.
   input  wire logic              clkRunIn,              // Clock-run level.
   output logic                   clkRunOut,             // Clock-run drive.
   output logic                   clkRunOeN,             // Low pulls it low.
   output logic                   bus64Mode,             // 64-bit bus.
   output logic                   assume100MHz,          // 100MHz assumed.
   output busmode_t               busMode,               // Sensed bus mode.
   output logic                   busModeValid,          // Bus mode sensed.
   input  wire logic              tck,                   // Test clock.
   input  wire logic              trstN,                 // Test reset.
   input  wire logic              tms,                   // Test mode select.
   input  wire logic              tdi,                   // Test data in.
   output logic                   tdo                    // Test data out.
);
   if (GPIO_N < 1 || GPIO_N > DATA_W) begin : g_bad
      $error("GPIO_N out of range.");
   end

   // ======================================================================
   // Register bus
   logic [GPIO_N-1:0] gpioOe_r;
   logic [GPIO_N-1:0] gpioOut_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [IRQ_W-1:0]  irqSt_r;
   logic [IRQ_W-1:0]  irqMask_r;
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] rdMux;
   logic              spsel_r;
   logic              width64_r;
   logic              freq100_r;
   logic              hot_swap_enable_in_r;
   logic              swPrev_r;
   logic              modeDone_r;
   logic              led_r;
   logic [IRQ_W-1:0]  ev;
   logic              stRead;

   function automatic logic hit(logic s, logic [ADDR_W-1:0] a,
                                logic [ADDR_W-1:0] off);
      hit = s && (a == off);
   endfunction : hit

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         gpioOe_r  <= '0;
         gpioOut_r <= '0;
      end else begin
         if (hit(regWr, regAddr, A_GPIO_OE))  gpioOe_r  <= regWdata[GPIO_N-1:0];
         if (hit(regWr, regAddr, A_GPIO_OUT)) gpioOut_r <= regWdata[GPIO_N-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_r    <= CTRL_RST;
         irqMask_r <= '0;
      end else begin
         if (hit(regWr, regAddr, A_CTRL))     ctrl_r    <= regWdata[CTRL_W-1:0];
         if (hit(regWr, regAddr, A_IRQ_MASK)) irqMask_r <= regWdata[IRQ_W-1:0];
      end
   end

   always_comb begin
      rdMux = '0;
      case (regAddr)
         A_GPIO_OE:  rdMux[GPIO_N-1:0] = gpioOe_r;
         A_GPIO_OUT: rdMux[GPIO_N-1:0] = gpioOut_r;
         A_GPIO_IN:  rdMux[GPIO_N-1:0] = gpioIn;
         A_STRAP:    rdMux[11:0] = {clkRunIn, pmeIn, serialDataIn, serialClkIn,
                                    hotSwapSwitchIn, busModeValid, busMode,
                                    hot_swap_enable_in_r, freq100_r, width64_r, spsel_r};
         A_CTRL:     rdMux[CTRL_W-1:0] = ctrl_r;
         A_IRQ_ST:   rdMux[IRQ_W-1:0] = irqSt_r;
         A_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_r;
         default:    rdMux = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst)    rdData_r <= '0;
      else if (regRd) rdData_r <= rdMux;
      else            rdData_r <= '0;
   end
   assign regRdata = rdData_r;

   // ======================================================================
   // Straps
   // The straps are caught on every clock while reset is high and frozen afterwards, so a
   // strap that bounces while running cannot change the bus personality.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         spsel_r   <= serialPortSelectStrap;
         width64_r <= busWidthStrap;
         freq100_r <= frequencySelectStrap;
         hot_swap_enable_in_r    <= hotSwapEnableIn;
      end
   end
   assign bus64Mode    = width64_r;
   assign assume100MHz = freq100_r;

   // ======================================================================
   // General pins and serial port
   assign gpioOut = gpioOut_r;
   assign gpioOeN = ~gpioOe_r;

   assign serialClkOut  = ctrl_r[C_CLK];
   assign serialClkOeN  = spsel_r;
   assign serialDataOut = spsel_r ? 1'b0 : ctrl_r[C_DAT];
   assign serialDataOeN = spsel_r ? ctrl_r[C_DAT] : ~ctrl_r[C_DATDIR];

   // ======================================================================
   // Bus mode sensing
   cap_sense_if cs ();
   assign cs.pinLevel           = capabilitySensePin;
   assign capabilityPullupDrive = cs.pullHigh;
   assign busMode               = cs.mode;
   assign busModeValid          = cs.done;

   cap_sense #(.CHARGE(CHARGE), .SETTLE(SETTLE)) u_cap (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .cs      (cs.sense)
   );

   // ======================================================================
   // Hot swap, events and interrupt
   // The switch history is loaded at reset so a board that is already seated
   // does not report a fresh insertion.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         swPrev_r   <= hotSwapSwitchIn;
         modeDone_r <= 1'b0;
      end else begin
         swPrev_r   <= hotSwapSwitchIn;
         modeDone_r <= cs.done;
      end
   end

   assign ev[I_INS]  = hot_swap_enable_in_r && hotSwapSwitchIn && !swPrev_r;
   assign ev[I_EXT]  = hot_swap_enable_in_r && !hotSwapSwitchIn && swPrev_r;
   assign ev[I_MODE] = cs.done && !modeDone_r;
   assign stRead     = hit(regRd, regAddr, A_IRQ_ST);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) irqSt_r <= '0;
      else         irqSt_r <= (stRead ? '0 : irqSt_r) | ev;
   end
   assign irq = |(irqSt_r & irqMask_r);

   assign enumOut = 1'b0;
   assign enumOeN = ~(irqSt_r[I_INS] | irqSt_r[I_EXT]);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) led_r <= 1'b0;
      else         led_r <= hot_swap_enable_in_r && !hotSwapSwitchIn && ctrl_r[C_LED];
   end
   assign extractionLedOut = led_r;

   // ======================================================================
   // Power event and clock-run
   assign pmeOut    = 1'b0;
   assign pmeOeN    = ~ctrl_r[C_PME];
   assign clkRunOut = 1'b0;
   assign clkRunOeN = ctrl_r[C_CLKSTP];

   // ======================================================================
   // Test access port
   tap_ctrl #(.IR_W(4)) u_tap (
      .tck   (tck),
      .trstN (trstN),
      .tms   (tms),
      .tdi   (tdi),
      .tdo   (tdo)
   );

   // ======================================================================
   // Checks
   localparam int MODE_MAX = SETTLE + 2;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence oeWrite;
      hit(regWr, regAddr, A_GPIO_OE);
   endsequence
   sequence relCharge;
      $fell(capabilityPullupDrive);
   endsequence

   a_gpio_dir: assert property (oeWrite |=> gpioOeN == ~$past(regWdata[GPIO_N-1:0]))
      else $error("General pin direction not taken from write.");
   a_clk_strap: assert property ($fell(sys_rst) |-> serialClkOeN == $past(serialPortSelectStrap))
      else $error("Serial clock direction does not follow strap.");
   a_data_od: assert property (spsel_r && !serialDataOeN |-> !serialDataOut)
      else $error("Serial data drives high in open-drain mode.");
   a_strap_hold: assert property (!$past(sys_rst) |-> $stable(bus64Mode) && $stable(assume100MHz))
      else $error("Strap value changed outside reset.");
   a_mode_sense: assert property (relCharge |-> ##[1:MODE_MAX] busModeValid)
      else $error("Bus mode not sensed after charge.");
   a_hs_off: assert property (!hot_swap_enable_in_r |-> enumOeN && !extractionLedOut)
      else $error("Hot-swap output active while disabled.");
   a_enum_evt: assert property ($rose(hotSwapSwitchIn) && hot_swap_enable_in_r |=> !enumOeN && irqSt_r[I_INS])
      else $error("Insertion did not pull enumeration low.");
   a_pme_req: assert property (hit(regWr, regAddr, A_CTRL) && regWdata[C_PME] |=> !pmeOeN)
      else $error("Power event not asserted on request.");
   a_led_on: assert property (hot_swap_enable_in_r && !hotSwapSwitchIn && ctrl_r[C_LED] |=> extractionLedOut)
      else $error("Extraction LED not lit.");
endmodule : strap_sideband_and_hot_swap

// ---- tb/cap_term_model.sv ----
`timescale 1ns/1ns
// ====================
// Board termination on the capability sense pin
module cap_term_model import sideband_pkg::*; (
   input  wire logic     ref_clk, // Bus clock.
   input  wire busmode_t term,    // Fitted termination.
   input  wire logic     pullEn,  // Pull-up drive from the block.
   output logic          pin      // Sense pin level.
);
   // A bare capacitor keeps its charge once the pull-up lets go.
   // The resistor drains it within a cycle, so a late sample sees low.
   always_ff @(posedge ref_clk) begin
      if (term == MODE_CONV)
         pin <= 1'b0;
      else if (pullEn)
         pin <= 1'b1;
      else if (term == MODE_X66)
         pin <= 1'b0;
   end
endmodule : cap_term_model

// ---- tb/test_strap_sideband_and_hot_swap.sv ----
`timescale 1ns/1ns
module test_strap_sideband_and_hot_swap import sideband_pkg::*; ;
   // ====================
   // Stimulus, wires and counters
   logic        ref_clk = 0, sys_rst = 1, regWr = 0, regRd = 0, swIn = 0;
   logic [7:0]  regAddr = 0;
   logic [31:0] regWdata = 0, regRdata, d;
   logic [6:0]  gpioDrv = 7'h2A, gpioOut, gpioOeN, gpioPin;
   logic        spSel = 0, width = 0, freq = 0, hot_swap_enable_in = 0, tck = 0, trstN = 0, tms = 0, tdi = 0;
   logic        irq, sClkOut, sClkOeN, sDatOut, sDatOeN, capPin, capPull, led, enumOut, enumOeN;
   logic        pmeOut, pmeOeN, crOut, crOeN, bus64, f100, valid, tdo;
   busmode_t    busMode, term = MODE_CONV;
   int          errorCnt = 0, checks = 0;
   assign gpioPin = (gpioOut & ~gpioOeN) | (gpioDrv & gpioOeN);
   always #5 ref_clk = ~ref_clk;
   cap_term_model board_u (.ref_clk(ref_clk), .term(term), .pullEn(capPull), .pin(capPin));
   strap_sideband_and_hot_swap #(.CHARGE(2), .SETTLE(3)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .irq(irq), .gpioIn(gpioPin), .gpioOut(gpioOut),
      .gpioOeN(gpioOeN), .serialPortSelectStrap(spSel), .busWidthStrap(width),
      .frequencySelectStrap(freq), .hotSwapEnableIn(hot_swap_enable_in), .hotSwapSwitchIn(swIn),
      .serialClkIn(sClkOeN ? 1'b1 : sClkOut), .serialClkOut(sClkOut), .serialClkOeN(sClkOeN),
      .serialDataIn(sDatOeN ? 1'b1 : sDatOut), .serialDataOut(sDatOut), .serialDataOeN(sDatOeN),
      .capabilitySensePin(capPin), .capabilityPullupDrive(capPull), .extractionLedOut(led),
      .enumOut(enumOut), .enumOeN(enumOeN), .pmeIn(pmeOeN ? 1'b1 : pmeOut), .pmeOut(pmeOut),
      .pmeOeN(pmeOeN), .clkRunIn(crOeN ? 1'b1 : crOut), .clkRunOut(crOut), .clkRunOeN(crOeN),
      .bus64Mode(bus64), .assume100MHz(f100), .busMode(busMode), .busModeValid(valid),
      .tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo));
   // ====================
   // Shared tasks
   task automatic final_report;
      if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(logic [7:0] a);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   // Straps are set here while reset is high, as the board would fit them.
   task automatic boot(logic s, logic w, logic f, logic h, busmode_t t);
      @(posedge ref_clk);
      {spSel, width, freq, hot_swap_enable_in, swIn, sys_rst} <= {s, w, f, h, 1'b0, 1'b1};
      term <= t;
      repeat (8) @(posedge ref_clk);
      #1 chk("capabilityPullupDrive", 1, capPull);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      tick(1);
   endtask : boot
   task automatic wait_valid;
      int n = 0;
      while (valid !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      if (n == 100) begin
         errorCnt++;
         final_report();
      end
   endtask : wait_valid
   task automatic tstep(logic m, logic i);
      @(posedge ref_clk);
      {tms, tdi} <= {m, i};
      @(posedge ref_clk);
      tck <= 1'b1;
      @(posedge ref_clk);
      tck <= 1'b0;
      tick(1);
   endtask : tstep
   // ====================
   // Scenarios
   task automatic scn_straps;
      busmode_t tbl [3] = '{MODE_CONV, MODE_X133, MODE_X66};
      for (int i = 0; i < 3; i++) begin
         boot(i == 1, i != 1, i == 2, 1'b0, tbl[i]);
         chk("gpioOeN", 7'h7F, gpioOeN);
         wait_valid();
         @(posedge ref_clk);
         {spSel, width, freq} <= ~{spSel, width, freq};
         tick(2);
         chk("busMode", tbl[i], busMode);
         chk("bus64Mode", i != 1, bus64);
         chk("assume100MHz", i == 2, f100);
         chk("serialClkOeN", i == 1, sClkOeN);
         rd(A_STRAP);
         chk("strapReg", {1'b0, 1'b1, i != 1, i == 1, 1'b0, 1'b1, tbl[i], 1'b0, i == 2, i != 1, i == 1},
             d[11:0]);
         wr(A_CTRL, 32'h0000_0007);
         chk("serialDataOeN", i == 1, sDatOeN);
         chk("serialClkOut", 1, sClkOut);
         chk("serialDataOut", i != 1, sDatOut);
         wr(A_CTRL, 32'h0000_0000);
         chk("serialDataOeN", i != 1, sDatOeN);
         @(posedge ref_clk);
         swIn <= 1'b1;
         tick(4);
         chk("enumOeN", 1, enumOeN);
      end
   endtask : scn_straps
   task automatic scn_gpio;
      wr(A_GPIO_OE, 32'h0000_0055);
      wr(A_GPIO_OUT, 32'h0000_0003);
      chk("gpioOeN", 7'h2A, gpioOeN);
      chk("gpioOut", 7'h03, gpioOut);
      rd(A_GPIO_IN);
      chk("gpioIn", 32'h0000_002B, d);
      rd(8'h40);
      chk("unmapped", 0, d);
   endtask : scn_gpio
   task automatic scn_hotswap;
      boot(1'b0, 1'b1, 1'b0, 1'b1, MODE_X133);
      wait_valid();
      rd(A_IRQ_ST);
      chk("irqStatus", 3'b100, d[2:0]);
      wr(A_IRQ_MASK, 32'h0000_0000);
      @(posedge ref_clk);
      swIn <= 1'b1;
      tick(3);
      chk("enumOeN", 0, enumOeN);
      chk("irq", 0, irq);
      wr(A_IRQ_MASK, 32'h0000_0001);
      chk("irq", 1, irq);
      rd(A_IRQ_ST);
      chk("irqStatus", 3'b001, d[2:0]);
      tick(1);
      chk("enumOeN", 1, enumOeN);
      chk("irq", 0, irq);
      wr(A_CTRL, 32'h0000_0020);
      @(posedge ref_clk);
      swIn <= 1'b0;
      tick(4);
      chk("extractionLedOut", 1, led);
      chk("enumOeN", 0, enumOeN);
      rd(A_IRQ_ST);
      chk("irqStatus", 3'b010, d[2:0]);
      for (int v = 1; v >= 0; v--) begin
         wr(A_CTRL, v ? 32'h0000_0018 : 32'h0000_0000);
         chk("pmeOeN", v == 0, pmeOeN);
         chk("clkRunOeN", v, crOeN);
      end
   endtask : scn_hotswap
   task automatic scn_tap;
      logic [5:0] pat = 6'b101101;
      @(posedge ref_clk);
      trstN <= 1'b1;
      @(posedge ref_clk);
      trstN <= 1'b0;
      tick(1);
      chk("tdo", 0, tdo);
      @(posedge ref_clk);
      trstN <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         tstep(0, 0);
         tstep(1, 0);
         tstep(0, 0);
         tstep(0, 0);
         for (int k = 0; k < 6; k++) begin
            tstep(0, pat[k]);
            chk("tdo", pat[k], tdo);
         end
         repeat (5) tstep(1, 0);
      end
      tstep(0, 0);
      tstep(1, 0);
      tstep(1, 0);
      tstep(0, 0);
      tstep(0, 0);
      chk("tdoIrCapture", 1, tdo);
      for (int k = 0; k < 7; k++) begin
         tstep(0, pat[k % 6]);
         chk("tdoIr", k < 3 ? 1'b0 : pat[(k + 3) % 6], tdo);
      end
      repeat (5) tstep(1, 0);
      tstep(0, 0);
      tstep(1, 0);
      tstep(0, 0);
      tstep(0, 1);
      tstep(0, 1);
      @(posedge ref_clk);
      trstN <= 1'b0;
      tick(2);
      chk("tdo", 0, tdo);
   endtask : scn_tap
   initial begin
      scn_straps();
      scn_gpio();
      scn_hotswap();
      scn_tap();
      final_report();
   end
endmodule : test_strap_sideband_and_hot_swap
